// >>> logic/asc_pkg.sv
// constants for the front end status and setup register bank
package asc_pkg;
	// ==========================================
	// register map
	localparam logic [4:0] STATUS_ADDR = 5'h0c;
	localparam logic [4:0] SETUP_ADDR = 5'h0d;
	localparam logic [4:0] WR_FIRST_ADDR = 5'h09;
	localparam logic [4:0] WR_LAST_ADDR = 5'h1f;
	// ==========================================
	// status_comm_reg layout
	localparam logic [23:0] STATUS_RESET = 24'ha10000;
	localparam logic [23:0] STATUS_WR_MASK = 24'hfff800;
	localparam int WR_INC_BIT = 21;
	localparam int PIN_DRIVE_BIT = 20;
	localparam int LINK_BIT = 19;
	localparam int CRC_WIDTH_BIT = 18;
	localparam int COMM_CRC_BIT = 15;
	localparam int ALARM_EN_BIT = 14;
	localparam int MOD_OUT_BIT = 11;
	// ==========================================
	// analog_setup_reg layout
	localparam logic [23:0] SETUP_RESET = 24'h386050;
	localparam logic [23:0] SETUP_WR_MASK = 24'hffe0ff;
	localparam int OFFSET_EN_BIT = 23;
	localparam int GAIN_EN_BIT = 22;
	// ==========================================
	// lock, checksum and timing
	localparam logic [7:0] UNLOCK_KEY = 8'ha5;
	localparam logic [15:0] CRC_SEED = 16'h0000;
	localparam logic [4:0] GAIN_DELAY_TICKS = 5'h18;
	localparam int GAIN_FRAC_BITS = 23;
endpackage

// >>> logic/asc_crc16.sv
// byte-wide checksum engine for one serial communication
module asc_crc16 #(
	parameter logic [15:0] POLY = 16'h1021
) (
	// clock and reset
	input wire logic i_sys_clk,
	input wire logic i_resetn,
	// byte stream
	input wire logic i_start,
	input wire logic i_byte_valid,
	input wire logic [7:0] i_byte,
	// result
	output logic [15:0] o_crc
);
	// ==========================================
	// shift one byte, msb first
	function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] b);
		logic [15:0] r;
		r = c;
		for (int i = 7; i >= 0; i--) begin
			r = (r[15] ^ b[i]) ? ((r << 1) ^ POLY) : (r << 1);
		end
		return r;
	endfunction

	logic [15:0] next_crc;

	always_comb begin
		next_crc = o_crc;
		// start wins so a new frame never inherits the old sum
		if (i_start) begin
			next_crc = asc_pkg::CRC_SEED;
		end else if (i_byte_valid) begin
			next_crc = crc_byte(o_crc, i_byte);
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_crc <= asc_pkg::CRC_SEED;
		end else begin
			o_crc <= next_crc;
		end
	end
endmodule

// >>> logic/asc_regs.sv
// status/communication and analog setup registers with ready logic
// Behaviour
// R1: linked mode pulses once, for slowest channel
// R2: wide format appends sixteen zero bits
// R3: enabled checksum error holds ready pin low
// R4: unlock key 0xa5 clears checksum alarm
// R5: host writes zero to bits 13-12
// R6: modulator outputs driven only when enabled
// R7: status bits 10-2 read zero
// R8: ready flags read 0 when data ready
// R9: status read sets ready flags to 1
// R10: data reads leave ready flags alone
// R11: offset correction adds no delay
// R12: gain correction delays data 24 ticks
// R13: checksum covers whole communication when enabled
// R14: write address increments, wraps writable range
module asc_regs #(
	parameter int NUM_CH = 2,
	parameter int DATA_W = 24
) (
	// clock and reset
	input wire logic i_sys_clk,
	input wire logic i_resetn,
	// register port from the serial engine
	input wire logic i_comm_start,
	input wire logic [4:0] i_comm_addr,
	input wire logic i_reg_wr,
	input wire logic [23:0] i_reg_wdata,
	input wire logic i_reg_rd,
	input wire logic [4:0] i_reg_addr,
	output logic [23:0] o_reg_rdata,
	output logic [4:0] o_wr_addr,
	// communication checksum
	input wire logic i_comm_byte_valid,
	input wire logic [7:0] i_comm_byte,
	output logic o_crc_append,
	output logic o_crc_wide,
	output logic [31:0] o_crc_field,
	// converters
	input wire logic i_mod_clk_tick,
	input wire logic [NUM_CH-1:0] i_conv_done,
	input wire logic [NUM_CH*DATA_W-1:0] i_conv_data,
	input wire logic [NUM_CH*DATA_W-1:0] i_offset_val,
	input wire logic [NUM_CH*DATA_W-1:0] i_gain_val,
	output logic [NUM_CH*DATA_W-1:0] o_chan_data,
	// configuration checksum and lock
	input wire logic i_cfg_crc_error,
	input wire logic [7:0] i_lock_key,
	// ready pin
	output logic o_ready_pin_n,
	output logic o_ready_pin_oe,
	// modulator outputs
	input wire logic [1:0] i_mod_bits,
	output logic [1:0] o_mod_out,
	output logic [1:0] o_mod_oe
);
	// ==========================================
	// register state
	logic [23:0] status_cfg;
	logic [23:0] setup_cfg;
	logic [4:0] wr_ptr;
	logic [23:0] rdata;
	logic [NUM_CH-1:0] ready_n;
	logic alarm;
	logic [NUM_CH-1:0] pending;
	logic pin_pulse;
	logic [23:0] next_status_cfg;
	logic [23:0] next_setup_cfg;
	logic [4:0] next_wr_ptr;
	logic [23:0] next_rdata;
	logic [NUM_CH-1:0] next_ready_n;
	logic next_alarm;
	logic [NUM_CH-1:0] next_pending;
	logic next_pin_pulse;
	logic [NUM_CH-1:0] chan_evt;
	logic [15:0] crc;
	logic status_rd;
	logic all_seen;

	assign status_rd = i_reg_rd && (i_reg_addr == asc_pkg::STATUS_ADDR);
	assign all_seen = &(pending | chan_evt);

	// ==========================================
	// per channel delay and correction
	for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
		logic [4:0] dly;
		logic [4:0] next_dly;
		logic [DATA_W-1:0] raw;
		logic [DATA_W-1:0] next_raw;
		logic [DATA_W-1:0] out;
		logic [DATA_W-1:0] next_out;
		logic signed [DATA_W-1:0] offs;
		logic signed [2*DATA_W-1:0] prod;
		logic fire;

		// R11: offset sum, no delay stage
		// offset only feeds the gain product when enabled
		assign offs = setup_cfg[asc_pkg::OFFSET_EN_BIT] ?
			DATA_W'($signed(raw) + $signed(i_offset_val[c*DATA_W +: DATA_W])) : $signed(raw);
		assign prod = offs * $signed(i_gain_val[c*DATA_W +: DATA_W]);
		assign fire = i_mod_clk_tick && (dly == 5'h01);
		// R12: 24 tick delay when gain on
		assign chan_evt[c] = setup_cfg[asc_pkg::GAIN_EN_BIT] ? fire : i_conv_done[c];
		assign o_chan_data[c*DATA_W +: DATA_W] = out;

		always_comb begin
			next_dly = dly;
			next_raw = raw;
			next_out = out;
			if (i_conv_done[c]) begin
				next_raw = i_conv_data[c*DATA_W +: DATA_W];
			end
			// a new result restarts a running delay
			if (i_conv_done[c] && setup_cfg[asc_pkg::GAIN_EN_BIT]) begin
				next_dly = asc_pkg::GAIN_DELAY_TICKS;
			end else if (i_mod_clk_tick && dly != 5'h00) begin
				next_dly = dly - 5'h01;
			end
			if (chan_evt[c]) begin
				next_out = i_conv_done[c] ? i_conv_data[c*DATA_W +: DATA_W] : raw;
				if (setup_cfg[asc_pkg::OFFSET_EN_BIT]) begin
					next_out = DATA_W'($signed(next_out)
						+ $signed(i_offset_val[c*DATA_W +: DATA_W]));
				end
				// R12: gain scaling, one plus fraction
				if (setup_cfg[asc_pkg::GAIN_EN_BIT]) begin
					next_out = DATA_W'($signed(next_out)
						+ (prod >>> asc_pkg::GAIN_FRAC_BITS));
				end
			end
		end

		always_ff @(posedge i_sys_clk or negedge i_resetn) begin
			if (!i_resetn) begin
				dly <= 5'h00;
				raw <= '0;
				out <= '0;
			end else begin
				dly <= next_dly;
				raw <= next_raw;
				out <= next_out;
			end
		end
	end

	// ==========================================
	// registers, flags, alarm, ready pin
	always_comb begin
		next_status_cfg = status_cfg;
		next_setup_cfg = setup_cfg;
		next_wr_ptr = wr_ptr;
		next_rdata = rdata;
		next_ready_n = ready_n;
		next_alarm = alarm;
		next_pending = pending;
		next_pin_pulse = 1'b0;
		if (i_comm_start) begin
			next_wr_ptr = i_comm_addr;
		end else if (i_reg_wr) begin
			if (wr_ptr == asc_pkg::STATUS_ADDR) begin
				next_status_cfg = i_reg_wdata & asc_pkg::STATUS_WR_MASK;
			end
			if (wr_ptr == asc_pkg::SETUP_ADDR) begin
				next_setup_cfg = i_reg_wdata & asc_pkg::SETUP_WR_MASK;
			end
			// R14: increment, wrap writable range
			if (status_cfg[asc_pkg::WR_INC_BIT]) begin
				next_wr_ptr = (wr_ptr == asc_pkg::WR_LAST_ADDR) ?
					asc_pkg::WR_FIRST_ADDR : wr_ptr + 5'h01;
			end
		end
		if (i_reg_rd) begin
			case (i_reg_addr)
				// R7: status bits 10-2 zero
				asc_pkg::STATUS_ADDR: next_rdata = {status_cfg[23:11], 9'h000, ready_n};
				asc_pkg::SETUP_ADDR: next_rdata = setup_cfg;
				default: next_rdata = 24'h000000;
			endcase
		end
		// R9: status read rearms flags
		if (status_rd) begin
			next_ready_n = '1;
		end
		// R8: ready clears flag, wins over read
		// R10: data reads not involved here
		next_ready_n = next_ready_n & ~chan_evt;
		// R4: unlock key clears alarm
		if (i_lock_key == asc_pkg::UNLOCK_KEY) begin
			next_alarm = 1'b0;
		end
		// R3: checksum error latches alarm
		if (i_cfg_crc_error && status_cfg[asc_pkg::ALARM_EN_BIT]) begin
			next_alarm = 1'b1;
		end
		// R1: link waits for slowest channel
		if (status_cfg[asc_pkg::LINK_BIT]) begin
			next_pending = all_seen ? '0 : (pending | chan_evt);
			next_pin_pulse = all_seen;
		end else begin
			next_pending = '0;
			next_pin_pulse = |chan_evt;
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			status_cfg <= asc_pkg::STATUS_RESET;
			setup_cfg <= asc_pkg::SETUP_RESET;
			wr_ptr <= asc_pkg::WR_FIRST_ADDR;
			rdata <= 24'h000000;
			ready_n <= '1;
			alarm <= 1'b0;
			pending <= '0;
			pin_pulse <= 1'b0;
		end else begin
			status_cfg <= next_status_cfg;
			setup_cfg <= next_setup_cfg;
			wr_ptr <= next_wr_ptr;
			rdata <= next_rdata;
			ready_n <= next_ready_n;
			alarm <= next_alarm;
			pending <= next_pending;
			pin_pulse <= next_pin_pulse;
		end
	end

	assign o_reg_rdata = rdata;
	assign o_wr_addr = wr_ptr;

	// ==========================================
	// outputs
	// R3: alarm overrides pulse, holds low
	assign o_ready_pin_n = ~(alarm | pin_pulse);
	// idle high is driven only when chosen, else pin floats
	assign o_ready_pin_oe = status_cfg[asc_pkg::PIN_DRIVE_BIT] | alarm | pin_pulse;
	// R6: modulator drive gated by enable
	assign o_mod_oe = {2{status_cfg[asc_pkg::MOD_OUT_BIT]}};
	assign o_mod_out = status_cfg[asc_pkg::MOD_OUT_BIT] ? i_mod_bits : 2'b00;

	// ==========================================
	// communication checksum
	// R13: sum over whole communication
	asc_crc16 u_crc (
		.i_sys_clk(i_sys_clk),
		.i_resetn(i_resetn),
		.i_start(i_comm_start),
		.i_byte_valid(i_comm_byte_valid),
		.i_byte(i_comm_byte),
		.o_crc(crc)
	);
	assign o_crc_append = status_cfg[asc_pkg::COMM_CRC_BIT];
	assign o_crc_wide = status_cfg[asc_pkg::CRC_WIDTH_BIT];
	// R2: wide form pads sixteen zeros
	assign o_crc_field = o_crc_wide ? {crc, 16'h0000} : {16'h0000, crc};
endmodule

// >>> verif/asc_regs_properties.sv
// port checker for the status and setup register bank
module asc_regs_properties (
	input wire logic i_sys_clk,
	input wire logic i_resetn,
	input wire logic i_comm_start,
	input wire logic [4:0] i_comm_addr,
	input wire logic i_comm_byte_valid,
	input wire logic i_reg_rd,
	input wire logic [4:0] i_reg_addr,
	input wire logic [23:0] o_reg_rdata,
	input wire logic [4:0] o_wr_addr,
	input wire logic o_crc_wide,
	input wire logic [31:0] o_crc_field,
	input wire logic o_ready_pin_n,
	input wire logic o_ready_pin_oe,
	input wire logic [1:0] i_mod_bits,
	input wire logic [1:0] o_mod_out,
	input wire logic [1:0] o_mod_oe
);
	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (!i_resetn);
	// ==========================================
	// properties
	AST_STAT_ZERO: assert property (
		i_reg_rd && i_reg_addr == asc_pkg::STATUS_ADDR |=> o_reg_rdata[10:2] == 9'h0)
		else $error("status gap bits set");
	AST_MOD_OFF: assert property (
		o_mod_oe == 2'h0 |-> o_mod_out == 2'h0) else $error("idle outputs move");
	AST_MOD_PASS: assert property (
		o_mod_oe == 2'h3 |-> o_mod_out == i_mod_bits) else $error("enabled outputs wrong");
	AST_MOD_BOTH: assert property (
		o_mod_oe == 2'h0 || o_mod_oe == 2'h3) else $error("outputs split");
	AST_CRC_WIDE: assert property (
		o_crc_wide |-> o_crc_field[15:0] == 16'h0) else $error("wide tail not zero");
	AST_CRC_NARROW: assert property (
		!o_crc_wide |-> o_crc_field[31:16] == 16'h0) else $error("narrow head not zero");
	AST_CRC_SEED: assert property (
		i_comm_start && !i_comm_byte_valid |=> o_crc_field == 32'h0) else $error("no reseed");
	AST_WR_PTR: assert property (
		i_comm_start |=> o_wr_addr == $past(i_comm_addr)) else $error("pointer not loaded");
	AST_PIN_OE: assert property (
		!o_ready_pin_n |-> o_ready_pin_oe) else $error("low pin not driven");
endmodule

bind asc_regs asc_regs_properties chk_u (.i_sys_clk, .i_resetn, .i_comm_start, .i_comm_addr,
	.i_comm_byte_valid, .i_reg_rd, .i_reg_addr, .o_reg_rdata, .o_wr_addr, .o_crc_wide,
	.o_crc_field, .o_ready_pin_n, .o_ready_pin_oe, .i_mod_bits, .o_mod_out, .o_mod_oe);

// >>> verif/asc_host_model.sv
// host side of the register port
module asc_host_model (
	// clock
	input wire logic i_sys_clk,
	// register port
	output logic o_comm_start = 1'b0,
	output logic [4:0] o_comm_addr = 5'h0,
	output logic o_reg_wr = 1'b0,
	output logic [23:0] o_reg_wdata = 24'h0,
	output logic o_reg_rd = 1'b0,
	output logic [4:0] o_reg_addr = 5'h0,
	input wire logic [23:0] i_reg_rdata
);
	logic [4:0] ptr = 5'h0;
	// ==========================================
	// transfers
	// each strobe drives its own signal: a copied argument would never pulse
	task automatic comm(input logic [4:0] a);
		o_comm_addr = a;
		ptr = a;
		@(posedge i_sys_clk);
		#1 o_comm_start = 1'b1;
		@(posedge i_sys_clk);
		#1 o_comm_start = 1'b0;
	endtask
	task automatic wr(input logic [23:0] d);
		if (ptr == asc_pkg::STATUS_ADDR) d[13:12] = 2'h0;
		o_reg_wdata = d;
		ptr = ptr + 5'h1;
		@(posedge i_sys_clk);
		#1 o_reg_wr = 1'b1;
		@(posedge i_sys_clk);
		#1 o_reg_wr = 1'b0;
	endtask
	task automatic rd(input logic [4:0] a, output logic [23:0] v);
		o_reg_addr = a;
		@(posedge i_sys_clk);
		#1 o_reg_rd = 1'b1;
		@(posedge i_sys_clk);
		#1 o_reg_rd = 1'b0;
		v = i_reg_rdata;
	endtask
endmodule

// >>> verif/asc_regs_test.sv
// self-checking bench for the status and setup register bank
module asc_regs_test;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 0, rstn = 0, cs, wr, rd, bv = 0, tick = 0, cerr = 0, pin_n, pin_oe, app, wide;
	logic [4:0] ca, ra, wa;
	logic [7:0] bt = 0, key = 0;
	logic [1:0] done = 0, mb = 0, mo, moe, flags = 2'h3;
	logic [23:0] wd, rdat, w, s, stat = asc_pkg::STATUS_RESET, setup = asc_pkg::SETUP_RESET;
	logic [31:0] crcf;
	logic [47:0] cdat = 0, offv = 0, gv = 0, chan;
	logic [15:0] mcrc = 16'h0;
	integer seed = 32'hd98e;
	int errors = 0, total_checks = 0, cyc = 0;
	asc_host_model host_u (.i_sys_clk(clk), .o_comm_start(cs), .o_comm_addr(ca),
		.o_reg_wr(wr), .o_reg_wdata(wd), .o_reg_rd(rd), .o_reg_addr(ra), .i_reg_rdata(rdat));
	asc_regs dut_u (.i_sys_clk(clk), .i_resetn(rstn), .i_comm_start(cs), .i_comm_addr(ca),
		.i_reg_wr(wr), .i_reg_wdata(wd), .i_reg_rd(rd), .i_reg_addr(ra), .o_reg_rdata(rdat),
		.o_wr_addr(wa), .i_comm_byte_valid(bv), .i_comm_byte(bt), .o_crc_append(app),
		.o_crc_wide(wide), .o_crc_field(crcf), .i_mod_clk_tick(tick), .i_conv_done(done),
		.i_conv_data(cdat), .i_offset_val(offv), .i_gain_val(gv), .o_chan_data(chan),
		.i_cfg_crc_error(cerr), .i_lock_key(key), .o_ready_pin_n(pin_n),
		.o_ready_pin_oe(pin_oe), .i_mod_bits(mb), .o_mod_out(mo), .o_mod_oe(moe));
	// ==========================================
	// helpers
	task automatic chk(input logic [47:0] got, input logic [47:0] exp);
		total_checks++;
		if (got !== exp) begin
			errors++;
			$display("FAIL %0t got %h exp %h", $time, got, exp);
		end
	endtask
	function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] b);
		for (int i = 7; i >= 0; i--) begin
			c = (c[15] ^ b[i]) ? ((c << 1) ^ 16'h1021) : (c << 1);
		end
		return c;
	endfunction
	// offset first, then one plus fraction gain, both wrapping
	function automatic logic [23:0] corr(input logic [23:0] d, input logic [23:0] o,
		input logic [23:0] g);
		logic signed [23:0] x;
		logic signed [47:0] p;
		x = setup[23] ? 24'(d + o) : d;
		p = x * $signed(g);
		return setup[22] ? 24'(x + (p >>> 23)) : x;
	endfunction
	task automatic tally_and_finish;
		$display("checks %0d errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic look(input logic [4:0] a, input logic [23:0] e);
		logic [23:0] v;
		host_u.rd(a, v);
		chk(v, e);
		if (a == asc_pkg::STATUS_ADDR) flags = 2'h3;
	endtask
	task automatic ev(input int ch, input logic ep);
		@(posedge clk);
		#1 cdat[ch*24+:24] = 24'($random(seed));
		offv[ch*24+:24] = 24'($random(seed));
		done[ch] = 1'b1;
		@(posedge clk);
		#1 done = 2'h0;
		flags[ch] = 1'b0;
		chk(pin_n, ep);
		chk(chan[ch*24+:24], corr(cdat[ch*24+:24], offv[ch*24+:24], gv[ch*24+:24]));
	endtask
	// ==========================================
	// clock, traffic and hang limit
	initial forever #12.5 clk = ~clk;
	always @(posedge clk) begin
		cyc++;
		if (cyc == 5000) begin
			errors++;
			tally_and_finish;
		end
	end
	always @(posedge clk) begin
		#1 {bv, bt} = 9'($random(seed));
		mb = 2'($random(seed));
	end
	// reference checksum over the random byte stream
	always @(posedge clk or negedge rstn) begin
		if (!rstn)
			mcrc <= 16'h0;
		else if (cs)
			mcrc <= 16'h0;
		else if (bv)
			mcrc <= crc_step(mcrc, bt);
	end
	// ==========================================
	// scenarios
	initial begin
		repeat (8) @(posedge clk);
		#1 rstn = 1'b1;
		look(asc_pkg::STATUS_ADDR, 24'ha10003);
		for (int k = 0; k < 2; k++) begin
			w = 24'($random(seed));
			{w[21:19], w[14], w[11]} = {2'h2, k[0], 1'b1, k[0]};
			s = 24'($random(seed));
			{s[23], s[22]} = {k[0], 1'b0};
			host_u.comm(asc_pkg::STATUS_ADDR);
			host_u.wr(w);
			host_u.wr(s);
			stat = w & asc_pkg::STATUS_WR_MASK & 24'hffcfff;
			setup = s & asc_pkg::SETUP_WR_MASK;
			chk(wa, asc_pkg::SETUP_ADDR + 5'h01);
			look(asc_pkg::STATUS_ADDR, {stat[23:11], 9'h0, flags});
			chk(app, stat[15]);
			chk(wide, stat[18]);
			chk(crcf, stat[18] ? {mcrc, 16'h0000} : {16'h0000, mcrc});
			look(asc_pkg::SETUP_ADDR, setup);
			look(5'h00, 24'h0);
			chk(moe, k[0] ? 2'h3 : 2'h0);
			#5 chk(mo, k[0] ? mb : 2'h0);
			ev(0, k[0]);
			ev(1, 1'b0);
			look(asc_pkg::STATUS_ADDR, {stat[23:11], 9'h0, flags});
			look(asc_pkg::STATUS_ADDR, {stat[23:11], 9'h0, flags});
		end
		setup[22] = 1'b1;
		host_u.comm(asc_pkg::SETUP_ADDR);
		host_u.wr(setup);
		@(posedge clk);
		#1 done = 2'h3;
		gv = {24'($random(seed)), 24'($random(seed))};
		@(posedge clk);
		#1 done = 2'h0;
		tick = 1'b1;
		repeat (23) @(posedge clk);
		#1 chk(pin_n, 1'b1);
		@(posedge clk);
		#1 chk(pin_n, 1'b0);
		chk(chan[23:0], corr(cdat[23:0], offv[23:0], gv[23:0]));
		chk(chan[47:24], corr(cdat[47:24], offv[47:24], gv[47:24]));
		tick = 1'b0;
		flags = 2'h0;
		look(asc_pkg::STATUS_ADDR, {stat[23:11], 9'h0, flags});
		cerr = 1'b1;
		@(posedge clk);
		#1 cerr = 1'b0;
		repeat (4) @(posedge clk);
		#1 chk({pin_n, pin_oe}, 2'h1);
		key = asc_pkg::UNLOCK_KEY;
		repeat (2) @(posedge clk);
		#1 chk(pin_n, 1'b1);
		tally_and_finish;
	end
endmodule
